// [shared/snsr_defs.svh]
// Purpose: constants of the serial nor status and read front end
// Assumes: status bit layout fixed below, 100 MHz system clock
// Notes: included by bare name
`ifndef SNSR_DEFS_SVH
`define SNSR_DEFS_SVH

// opcodes
`define SNSR_OP_WRITE_ENABLE 8'h06
`define SNSR_OP_WRITE_DISABLE 8'h04
`define SNSR_OP_STATUS_LO 8'h05
`define SNSR_OP_STATUS_HI 8'h35
`define SNSR_OP_VOLATILE_ENABLE 8'h50
`define SNSR_OP_STATUS_WRITE 8'h01
`define SNSR_OP_READ 8'h03
`define SNSR_OP_FAST_READ 8'h0b
`define SNSR_OP_DUAL_OUT 8'h3b
`define SNSR_OP_QUAD_OUT 8'h6b
`define SNSR_OP_DUAL_IO 8'hbb
`define SNSR_OP_QUAD_IO 8'heb
`define SNSR_OP_SEC_READ 8'h48

// status bit positions
`define SNSR_S_WIP 0
`define SNSR_S_WEL 1
`define SNSR_S_STATUS_PROTECT_BIT_LO 7
`define SNSR_S_STATUS_PROTECT_BIT_HI 8
`define SNSR_S_QE 9
`define SNSR_S_CMP 14
`define SNSR_S_TOP 15

// reset values and codes
`define SNSR_NV_RESET 16'h0000
`define SNSR_XIP_MODE 2'h2
`define SNSR_SEC_SELECT_MAX 8'h03
`define SNSR_BLANK_BYTE 8'hff

// timing
`define SNSR_STATUS_WRITE_TIME_NS 5000000
`define SNSR_CLOCK_PERIOD_NS 10

`endif

// [shared/snsr_pkg.sv]
// Purpose: types of the serial nor status and read front end
// Assumes: nothing
// Notes: link phase encoding
`default_nettype none
package snsr_pkg;
	typedef enum logic [2:0] {
		ST_OPCODE = 3'b000,
		ST_ADDR = 3'b001,
		ST_MODE = 3'b010,
		ST_DUMMY = 3'b011,
		ST_DATA = 3'b100,
		ST_SINK = 3'b101
	} snsr_link_state_type;
endpackage : snsr_pkg
`default_nettype wire

// [logic/snsr_byte_mem.sv]
// Purpose: byte array, written on one clock, read on another
// Assumes: read address presented before the read edge
// Notes: read data come out of a register
`default_nettype none
module snsr_byte_mem #(
	parameter int ADDR_W = 10,
	parameter int DATA_W = 8
) (
	// write side
	input wire logic wr_clock,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data,
	// read side
	input wire logic rd_clock,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [DATA_W-1:0] rd_data
);
	logic [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] rd_data_q;

	if (ADDR_W < 1 || ADDR_W > 24 || DATA_W < 1) begin : g_bad
		$error("snsr_byte_mem: unsupported size");
	end

	always_ff @(posedge wr_clock) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge rd_clock) begin
		rd_data_q <= mem_q[rd_addr];
	end

	assign rd_data = rd_data_q;
endmodule : snsr_byte_mem
`default_nettype wire

// [logic/snsr_flash_front.sv]
// Purpose: command front end of a serial nor flash, status and read instructions
// Assumes: sclk stops before chip select rises; memory preloaded through the load port
// Notes: link logic on sclk, status logic on clock
//
// Summary of operation
// - dual data: io1 odd bits, io0 even; quad: io3..io0 high nibble first
// - dual address: io1 odd address then odd mode bits, io0 even ones
// - quad address: four bits per clock, io3 most significant, then mode nibbles
// - quad io read: four dummy clocks after mode byte, then nibbles high first
// - security read: upper byte zero, middle byte selects register 0..3
// - write enable opcode framed alone sets the write enable latch
// - write disable, power-up and write completions clear the latch
// - 05h shifts status low byte, 35h high byte, repeating, anytime
// - status write accepted only with write enable latch set or armed by 50h
// - status write never changes bits 15, 1 and 0
// - status write needs 8 or 16 data bits, else no effect beyond clearing the 50h arm
// - one byte status write clears complement, quad enable, protect high
// - non-volatile status write runs timed cycle, wip high, latch cleared at end
// - status writes refused under hardware protection
// - 50h arms next status write to volatile copy; reset loads copy
// - normal read: address on rising edges, data on falling, increments
// - normal read refused while a write cycle runs
// - fast read: address plus dummy byte, then serial data, increments
// - dual output read: serial address, dummy byte, two bits per clock
// - quad output read: serial address, dummy byte, four bits per clock
// - dual io read: address and mode on two lanes, two-bit data
// - mode bits 5..4 equal 10 skip the opcode of the next frame
`default_nettype none
`include "snsr_defs.svh"
module snsr_flash_front import snsr_pkg::*; #(
	parameter int ADDR_W = 21,
	parameter int TW_CYCLES = `SNSR_STATUS_WRITE_TIME_NS / `SNSR_CLOCK_PERIOD_NS
) (
	// system clock and reset
	input wire logic clock,
	input wire logic reset,
	// serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [3:0] io_i,
	output logic [3:0] io_o,
	output logic [3:0] io_oe,
	// write protect pin
	input wire logic wp_n,
	// program and erase engine
	input wire logic array_busy,
	input wire logic array_done,
	// memory preload
	input wire logic load_en,
	input wire logic load_sec,
	input wire logic [ADDR_W-1:0] load_addr,
	input wire logic [7:0] load_data,
	// status
	output logic [15:0] status_word,
	output logic write_enable_latch,
	output logic write_in_progress_flag
);
	localparam int TW_W = $clog2(TW_CYCLES + 1);

	if (ADDR_W < 10 || ADDR_W > 24 || TW_CYCLES < 2) begin : g_bad
		$error("snsr_flash_front: unsupported parameters");
	end

	function automatic logic [23:0] shift_in(input logic [23:0] v, input logic [2:0] w, input logic [3:0] io);
		case (w)
			3'd2: shift_in = {v[21:0], io[1:0]};
			3'd4: shift_in = {v[19:0], io};
			default: shift_in = {v[22:0], io[0]};
		endcase
	endfunction : shift_in

	function automatic logic [2:0] in_lanes(input logic [7:0] op);
		case (op)
			`SNSR_OP_DUAL_IO: in_lanes = 3'd2;
			`SNSR_OP_QUAD_IO: in_lanes = 3'd4;
			default: in_lanes = 3'd1;
		endcase
	endfunction : in_lanes

	function automatic logic [2:0] out_lanes(input logic [7:0] op);
		case (op)
			`SNSR_OP_DUAL_OUT, `SNSR_OP_DUAL_IO: out_lanes = 3'd2;
			`SNSR_OP_QUAD_OUT, `SNSR_OP_QUAD_IO: out_lanes = 3'd4;
			default: out_lanes = 3'd1;
		endcase
	endfunction : out_lanes

	function automatic logic [4:0] lane_clks(input logic [2:0] w, input logic [4:0] bits);
		case (w)
			3'd2: lane_clks = bits >> 1;
			3'd4: lane_clks = bits >> 2;
			default: lane_clks = bits;
		endcase
	endfunction : lane_clks

	function automatic logic [15:0] status_merge(input logic [15:0] old, input logic [15:0] din, input logic two);
		logic [15:0] v;
		v = old;
		if (two) begin
			v[14:8] = din[6:0];
			v[7:2] = din[15:10];
		end else begin
			v[7:2] = din[7:2];
			v[`SNSR_S_CMP] = 1'b0;
			v[`SNSR_S_QE] = 1'b0;
			v[`SNSR_S_STATUS_PROTECT_BIT_HI] = 1'b0;
		end
		return v;
	endfunction : status_merge

	////////////////////////////////////////////////////////////////////////
	// link side, sclk domain

	snsr_link_state_type state_q;
	logic [4:0] cnt_q;
	logic [2:0] beat_q;
	logic [5:0] clk_cnt_q;
	logic [7:0] op_q;
	logic [7:0] mode_q;
	logic [23:0] addr_q;
	logic [23:0] addr_d;
	logic [ADDR_W-1:0] addr_inc;
	logic [23:0] mode_sh;
	logic [7:0] op_in;
	logic xip_q;
	logic [7:0] xip_op_q;
	logic frame_tog_q;
	logic [7:0] res_op_q;
	logic [5:0] res_total_q;
	logic [15:0] res_din_q;
	logic [15:0] st_s1_q;
	logic [15:0] st_s2_q;
	logic [3:0] io_o_q;
	logic [3:0] io_oe_q;
	logic [7:0] out_sr_q;
	logic [7:0] main_q;
	logic [7:0] sec_q;
	logic [7:0] src_byte;
	logic [7:0] cur_byte;
	logic [2:0] in_w;
	logic [2:0] out_w;
	logic busy_s;
	logic qe_s;
	logic sec_ok;

	assign in_w = in_lanes(op_q);
	assign out_w = out_lanes(op_q);
	assign busy_s = st_s2_q[`SNSR_S_WIP];
	assign qe_s = st_s2_q[`SNSR_S_QE];
	assign op_in = addr_d[7:0];
	// array-sized increment, carry out of the top dropped
	assign addr_inc = addr_q[ADDR_W-1:0] + ADDR_W'(1);
	assign mode_sh = shift_in({16'h0000, mode_q}, in_w, io_i);
	assign sec_ok = addr_q[23:16] == 8'h00 && addr_q[15:8] <= `SNSR_SEC_SELECT_MAX;

	always_comb begin
		addr_d = addr_q;
		case (state_q)
			ST_OPCODE: addr_d = shift_in(addr_q, xip_q ? in_lanes(xip_op_q) : 3'd1, io_i);
			ST_ADDR: addr_d = shift_in(addr_q, in_w, io_i);
			ST_DATA: begin
				if (beat_q == 3'd0) begin
					addr_d = 24'(addr_inc);
				end
			end
			default: addr_d = addr_q;
		endcase
	end

	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			state_q <= ST_OPCODE;
			cnt_q <= 5'h00;
			beat_q <= 3'h0;
			clk_cnt_q <= 6'h00;
			op_q <= 8'h00;
			mode_q <= 8'h00;
			addr_q <= 24'h000000;
		end else begin
			addr_q <= addr_d;
			if (clk_cnt_q != 6'h3f) begin
				clk_cnt_q <= clk_cnt_q + 6'h01;
			end
			case (state_q)
				ST_OPCODE: begin
					if (xip_q) begin
						op_q <= xip_op_q;
						cnt_q <= 5'h01;
						state_q <= ST_ADDR;
					end else if (cnt_q == 5'h07) begin
						op_q <= op_in;
						cnt_q <= 5'h00;
						beat_q <= 3'h0;
						case (op_in)
							`SNSR_OP_READ: state_q <= busy_s ? ST_SINK : ST_ADDR;
							`SNSR_OP_FAST_READ, `SNSR_OP_DUAL_OUT, `SNSR_OP_DUAL_IO, `SNSR_OP_SEC_READ: begin
								state_q <= ST_ADDR;
							end
							`SNSR_OP_QUAD_OUT, `SNSR_OP_QUAD_IO: state_q <= qe_s ? ST_ADDR : ST_SINK;
							`SNSR_OP_STATUS_LO, `SNSR_OP_STATUS_HI: state_q <= ST_DATA;
							default: state_q <= ST_SINK;
						endcase
					end else begin
						cnt_q <= cnt_q + 5'h01;
					end
				end
				ST_ADDR: begin
					if (cnt_q == lane_clks(in_w, 5'd24) - 5'd1) begin
						cnt_q <= 5'h00;
						if (op_q == `SNSR_OP_DUAL_IO || op_q == `SNSR_OP_QUAD_IO) begin
							state_q <= ST_MODE;
						end else if (op_q == `SNSR_OP_READ) begin
							state_q <= ST_DATA;
						end else begin
							state_q <= ST_DUMMY;
						end
					end else begin
						cnt_q <= cnt_q + 5'h01;
					end
				end
				ST_MODE: begin
					mode_q <= mode_sh[7:0];
					if (cnt_q == lane_clks(in_w, 5'd8) - 5'd1) begin
						cnt_q <= 5'h00;
						state_q <= op_q == `SNSR_OP_QUAD_IO ? ST_DUMMY : ST_DATA;
					end else begin
						cnt_q <= cnt_q + 5'h01;
					end
				end
				ST_DUMMY: begin
					if (cnt_q == (op_q == `SNSR_OP_QUAD_IO ? 5'd3 : 5'd7)) begin
						cnt_q <= 5'h00;
						state_q <= ST_DATA;
					end else begin
						cnt_q <= cnt_q + 5'h01;
					end
				end
				ST_DATA: begin
					beat_q <= beat_q == 3'(lane_clks(out_w, 5'd8) - 5'd1) ? 3'h0 : beat_q + 3'h1;
				end
				ST_SINK: state_q <= ST_SINK;
				default: state_q <= ST_SINK;
			endcase
		end
	end

	// continuous read mode survives deselection
	always_ff @(posedge sclk or posedge reset) begin
		if (reset) begin
			xip_q <= 1'b0;
			xip_op_q <= 8'h00;
		end else if (!cs_n && state_q == ST_MODE && cnt_q == lane_clks(in_w, 5'd8) - 5'd1) begin
			xip_q <= mode_sh[5:4] == `SNSR_XIP_MODE;
			xip_op_q <= op_q;
		end
	end

	// frame results handed to the clock domain
	always_ff @(posedge sclk or posedge reset) begin
		if (reset) begin
			frame_tog_q <= 1'b0;
			res_op_q <= 8'h00;
			res_total_q <= 6'h00;
			res_din_q <= 16'h0000;
		end else if (!cs_n) begin
			res_total_q <= clk_cnt_q == 6'h3f ? 6'h3f : clk_cnt_q + 6'h01;
			res_din_q <= {res_din_q[14:0], io_i[0]};
			if (clk_cnt_q == 6'h00) begin
				frame_tog_q <= ~frame_tog_q;
				res_op_q <= 8'h00;
			end else if (state_q == ST_OPCODE && !xip_q && cnt_q == 5'h07) begin
				res_op_q <= op_in;
			end
		end
	end

	always_ff @(posedge sclk or posedge reset) begin
		if (reset) begin
			st_s1_q <= 16'h0000;
			st_s2_q <= 16'h0000;
		end else begin
			st_s1_q <= status_word;
			st_s2_q <= st_s1_q;
		end
	end

	snsr_byte_mem #(.ADDR_W(ADDR_W), .DATA_W(8)) main_mem (
		.wr_clock(clock),
		.wr_en(load_en & ~load_sec),
		.wr_addr(load_addr),
		.wr_data(load_data),
		.rd_clock(sclk),
		.rd_addr(addr_d[ADDR_W-1:0]),
		.rd_data(main_q)
	);

	snsr_byte_mem #(.ADDR_W(10), .DATA_W(8)) sec_mem (
		.wr_clock(clock),
		.wr_en(load_en & load_sec),
		.wr_addr(load_addr[9:0]),
		.wr_data(load_data),
		.rd_clock(sclk),
		.rd_addr(addr_d[9:0]),
		.rd_data(sec_q)
	);

	always_comb begin
		if (op_q == `SNSR_OP_STATUS_LO) begin
			src_byte = st_s2_q[7:0];
		end else if (op_q == `SNSR_OP_STATUS_HI) begin
			src_byte = st_s2_q[15:8];
		end else if (op_q == `SNSR_OP_SEC_READ) begin
			src_byte = sec_ok ? sec_q : `SNSR_BLANK_BYTE;
		end else begin
			src_byte = main_q;
		end
	end

	assign cur_byte = beat_q == 3'h0 ? src_byte : out_sr_q;

	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			io_o_q <= 4'h0;
			io_oe_q <= 4'h0;
			out_sr_q <= 8'h00;
		end else if (state_q == ST_DATA) begin
			case (out_w)
				3'd4: begin
					io_o_q <= cur_byte[7:4];
					io_oe_q <= 4'hf;
					out_sr_q <= {cur_byte[3:0], 4'h0};
				end
				3'd2: begin
					io_o_q <= {2'b00, cur_byte[7:6]};
					io_oe_q <= 4'h3;
					out_sr_q <= {cur_byte[5:0], 2'b00};
				end
				default: begin
					io_o_q <= {2'b00, cur_byte[7], 1'b0};
					io_oe_q <= 4'h2;
					out_sr_q <= {cur_byte[6:0], 1'b0};
				end
			endcase
		end else begin
			io_o_q <= 4'h0;
			io_oe_q <= 4'h0;
		end
	end

	assign io_o = io_o_q;
	assign io_oe = io_oe_q;

	////////////////////////////////////////////////////////////////////////
	// status side, clock domain

	logic cs_s1_q, cs_s2_q, cs_s3_q;
	logic tog_s1_q, tog_s2_q, tog_seen_q;
	logic wp_s1_q, wp_s2_q;
	logic wel_q, vol_arm_q, wip_q;
	logic [TW_W-1:0] busy_cnt_q;
	logic [15:0] vol_q, nv_q, pend_q, stat_q, new_val;
	logic frame_ev, is_wren, is_wrdi, wsr_ok, wsr_vol, wsr_nv, wip_done, hw_prot;

	always_ff @(posedge clock) begin
		if (reset) begin
			{cs_s1_q, cs_s2_q, cs_s3_q} <= 3'h7;
			{tog_s1_q, tog_s2_q, tog_seen_q} <= 3'h0;
			{wp_s1_q, wp_s2_q} <= 2'h3;
		end else begin
			{cs_s1_q, cs_s2_q, cs_s3_q} <= {cs_n, cs_s1_q, cs_s2_q};
			{tog_s1_q, tog_s2_q} <= {frame_tog_q, tog_s1_q};
			{wp_s1_q, wp_s2_q} <= {wp_n, wp_s1_q};
			if (frame_ev) begin
				tog_seen_q <= tog_s2_q;
			end
		end
	end

	assign frame_ev = cs_s2_q && !cs_s3_q && tog_s2_q != tog_seen_q;
	assign is_wren = frame_ev && res_op_q == `SNSR_OP_WRITE_ENABLE && res_total_q == 6'd8;
	assign is_wrdi = frame_ev && res_op_q == `SNSR_OP_WRITE_DISABLE && res_total_q == 6'd8;
	assign hw_prot = vol_q[`SNSR_S_STATUS_PROTECT_BIT_HI] || (vol_q[`SNSR_S_STATUS_PROTECT_BIT_LO] && !wp_s2_q);
	assign wsr_ok = frame_ev && res_op_q == `SNSR_OP_STATUS_WRITE && (res_total_q == 6'd16 || res_total_q == 6'd24)
		&& (wel_q || vol_arm_q) && !hw_prot && !wip_q;
	assign wsr_vol = wsr_ok && vol_arm_q;
	assign wsr_nv = wsr_ok && !vol_arm_q;
	assign wip_done = wip_q && busy_cnt_q == '0;
	assign new_val = status_merge(vol_q, res_din_q, res_total_q == 6'd24);

	always_ff @(posedge clock) begin
		if (reset) begin
			wel_q <= 1'b0;
		end else if (is_wren) begin
			wel_q <= 1'b1;
		end else if (is_wrdi || array_done || wip_done) begin
			wel_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			vol_arm_q <= 1'b0;
		end else if (frame_ev && res_op_q == `SNSR_OP_VOLATILE_ENABLE && res_total_q == 6'd8) begin
			vol_arm_q <= 1'b1;
		end else if (frame_ev && res_op_q == `SNSR_OP_STATUS_WRITE) begin
			vol_arm_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			wip_q <= 1'b0;
			busy_cnt_q <= '0;
			pend_q <= 16'h0000;
		end else if (wsr_nv) begin
			wip_q <= 1'b1;
			busy_cnt_q <= TW_W'(TW_CYCLES - 1);
			pend_q <= new_val;
		end else if (wip_done) begin
			wip_q <= 1'b0;
		end else if (wip_q) begin
			busy_cnt_q <= busy_cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			nv_q <= `SNSR_NV_RESET;
			vol_q <= `SNSR_NV_RESET;
		end else if (wsr_vol) begin
			vol_q <= new_val;
		end else if (wip_done) begin
			nv_q <= pend_q;
			vol_q <= pend_q;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			stat_q <= 16'h0000;
		end else begin
			stat_q <= {vol_q[15:2], wel_q, wip_q || array_busy};
		end
	end

	assign status_word = stat_q;
	assign write_enable_latch = wel_q;
	assign write_in_progress_flag = wip_q;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_wel_set_wren: assert property (is_wren |=> wel_q) else $error("latch not set");
	a_wel_clear_wrdi: assert property (is_wrdi && !array_done |=> !wel_q) else $error("latch not cleared");
	a_wsr_needs_wel: assert property (frame_ev && res_op_q == `SNSR_OP_STATUS_WRITE && !wel_q && !vol_arm_q && !wip_q
		|=> !wip_q && $stable(vol_q)) else $error("status write without latch");
	a_wsr_keep_top: assert property (1'b1 |=> vol_q[`SNSR_S_TOP] == $past(vol_q[`SNSR_S_TOP]))
		else $error("bit 15 changed");
	a_wsr_bad_len: assert property (frame_ev && res_op_q == `SNSR_OP_STATUS_WRITE && res_total_q != 6'd16
		&& res_total_q != 6'd24 && !wip_q |=> !wip_q && $stable(vol_q)) else $error("short status write acted");
	a_wsr_one_byte: assert property (wsr_vol && res_total_q == 6'd16
		|=> !vol_q[`SNSR_S_CMP] && !vol_q[`SNSR_S_QE] && !vol_q[`SNSR_S_STATUS_PROTECT_BIT_HI]) else $error("bits not cleared");
	a_wip_cycle_run: assert property (wsr_nv |=> wip_q [*2]) else $error("write cycle too short");
	a_wip_end_wel: assert property (wip_done && !is_wren |=> !wip_q && !wel_q) else $error("latch kept");
	a_hw_protect: assert property (frame_ev && hw_prot && !wip_q |=> !wip_q && $stable(vol_q))
		else $error("protected write acted");
	a_read_busy: assert property (@(posedge sclk) disable iff (cs_n) state_q == ST_OPCODE && !xip_q
		&& cnt_q == 5'h07 && op_in == `SNSR_OP_READ && busy_s |=> state_q == ST_SINK)
		else $error("read accepted while busy");

	c_wel_set: cover property (is_wren);
	c_nv_write: cover property (wsr_nv ##1 wip_q);
	c_vol_write: cover property (wsr_vol);
	c_xip_arm: cover property (@(posedge sclk) $rose(xip_q));
endmodule : snsr_flash_front
`default_nettype wire

// [test/snsr_host_model.sv]
// Purpose: spi host model on the far side of the flash front link
// Assumes: mode 0, sclk idle low and still outside frames, 48 ns link period
// Notes: lane levels resolved here from the flash front's enables
`default_nettype none
module snsr_host_model (
	// link
	output logic sclk,
	output logic cs_n,
	output logic [3:0] io_i,
	input wire logic [3:0] io_o,
	input wire logic [3:0] io_oe,
	// received bytes
	output logic [7:0] rx_byte,
	output logic rx_valid
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] drive;
	assign io_i = (io_oe & io_o) | (~io_oe & drive);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b0;
		drive = 4'h0;
		rx_byte = 8'h00;
		rx_valid = 1'b0;
		// a real select edge clears the link state before any frame
		#1;
		cs_n = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////////
	// one clock: lanes set while low, wire sampled at the rising edge
	task automatic tick(input logic [3:0] d, output logic [3:0] s);
		drive = d;
		#24;
		s = io_i;
		sclk = 1'b1;
		#24;
		sclk = 1'b0;
	endtask : tick
	task automatic start();
		#13;
		cs_n = 1'b0;
	endtask : start
	// whole units, msb first, top bit on the highest lane
	task automatic put(input logic [31:0] v, input int nbits, input int lanes);
		logic [3:0] d;
		logic [3:0] s;
		for (int i = nbits; i > 0; i -= lanes) begin
			d = 4'($urandom);
			for (int k = 0; k < lanes; k++) d[k] = v[i - lanes + k];
			tick(d, s);
		end
	endtask : put
	task automatic get(input int nbytes, input int lanes);
		logic [3:0] s;
		logic [7:0] b;
		for (int n = 0; n < nbytes; n++) begin
			b = 8'h00;
			for (int i = 0; i < 8; i += lanes) begin
				tick(4'($urandom), s);
				b = lanes == 1 ? {b[6:0], s[1]} : lanes == 2 ? {b[5:0], s[1:0]} : {b[3:0], s};
			end
			rx_byte = b;
			rx_valid = 1'b1;
			#1;
			rx_valid = 1'b0;
		end
	endtask : get
	// chip select high long enough for the clock domain to take the frame
	task automatic stop();
		#10;
		cs_n = 1'b1;
		#100;
	endtask : stop
endmodule : snsr_host_model
`default_nettype wire

// [test/snsr_testbench.sv]
// Purpose: self-checking bench of the flash front status and read commands
// Assumes: shortened status write time, small array
// Notes: expected bytes queued by the driver, compared by the watcher
`default_nettype none
`include "snsr_defs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int AW = 10;
	localparam int TW = 200;
	logic clock;
	logic reset;
	logic sclk;
	logic cs_n;
	logic [3:0] io_i;
	logic [3:0] io_o;
	logic [3:0] io_oe;
	logic wp_n;
	logic array_busy;
	logic array_done;
	logic load_en;
	logic load_sec;
	logic [AW-1:0] load_addr;
	logic [7:0] load_data;
	logic [7:0] rx_byte;
	logic rx_valid;
	logic [15:0] status_word;
	logic write_enable_latch;
	logic write_in_progress_flag;
	logic [7:0] mem_m [0:1023];
	logic [7:0] sec_m [0:255];
	logic [7:0] exp_q [$];
	int failures = 0;
	int n_checks = 0;
	snsr_flash_front #(.ADDR_W(AW), .TW_CYCLES(TW)) i_dut (.clock(clock), .reset(reset), .sclk(sclk),
		.cs_n(cs_n), .io_i(io_i), .io_o(io_o), .io_oe(io_oe), .wp_n(wp_n), .array_busy(array_busy),
		.array_done(array_done), .load_en(load_en), .load_sec(load_sec), .load_addr(load_addr),
		.load_data(load_data), .status_word(status_word), .write_enable_latch(write_enable_latch),
		.write_in_progress_flag(write_in_progress_flag));
	snsr_host_model i_host (.sclk(sclk), .cs_n(cs_n), .io_i(io_i), .io_o(io_o), .io_oe(io_oe),
		.rx_byte(rx_byte), .rx_valid(rx_valid));
	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		if (exp_q.size() != 0) begin
			failures++;
			$display("mismatch at %0t: %0d expected bytes never arrived", $time, exp_q.size());
		end
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	always @(posedge rx_valid) begin
		if (exp_q.size() == 0) begin
			failures++;
			$display("mismatch at %0t: unexpected byte %h", $time, rx_byte);
		end else begin
			chk(rx_byte, exp_q.pop_front());
		end
	end
	task automatic op(input logic [7:0] c);
		i_host.start();
		i_host.put(32'(c), 8, 1);
		i_host.stop();
	endtask : op
	// v holds the data bits in its low nbits, first bit highest
	task automatic wsr(input logic [15:0] v, input int nbits);
		i_host.start();
		i_host.put(32'(`SNSR_OP_STATUS_WRITE), 8, 1);
		i_host.put(32'(v), nbits, 1);
		i_host.stop();
	endtask : wsr
	// opcode 00 means continuous mode: no opcode sent
	task automatic rd(input logic [7:0] c, input logic [23:0] a, input int ab, input int al, input int mb,
		input logic [7:0] m, input int dc, input int dl, input int nb);
		i_host.start();
		if (c != 8'h00) i_host.put(32'(c), 8, 1);
		i_host.put(32'(a), ab, al);
		i_host.put(32'(m), mb, al);
		i_host.put(32'h0, dc, 1);
		i_host.get(nb, dl);
		i_host.stop();
		chk(8'(io_oe), 8'h00);
	endtask : rd
	task automatic sr(input logic [7:0] c, input logic [7:0] e);
		exp_q.push_back(e);
		exp_q.push_back(e);
		rd(c, 24'h0, 0, 1, 0, 8'h00, 0, 1, 2);
	endtask : sr
	task automatic mr(input logic [7:0] c, input logic [23:0] a, input int al, input int mb, input logic [7:0] m,
		input int dc, input int dl);
		for (int i = 0; i < 3; i++) exp_q.push_back(mem_m[10'(a + 24'(i))]);
		rd(c, a, 24, al, mb, m, dc, dl, 3);
	endtask : mr
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		#400000;
		failures++;
		$display("mismatch at %0t: watchdog expired", $time);
		give_verdict();
	end
	initial begin
		logic [23:0] a;
		reset = 1'b0;
		wp_n = 1'b1;
		array_busy = 1'b0;
		array_done = 1'b0;
		load_en = 1'b0;
		load_sec = 1'b0;
		load_addr = '0;
		load_data = 8'h00;
		void'($urandom(60));
		// a real rising edge for the link side reset
		#1;
		reset = 1'b1;
		repeat (5) @(negedge clock);
		reset = 1'b0;
		for (int i = 0; i < 1280; i++) begin
			@(negedge clock);
			load_en = 1'b1;
			load_sec = i >= 1024;
			load_addr = i >= 1024 ? AW'(i - 512) : AW'(i);
			load_data = 8'($urandom);
			if (i < 1024) mem_m[i] = load_data;
			else sec_m[i - 1024] = load_data;
		end
		@(negedge clock);
		load_en = 1'b0;
		repeat (4) @(negedge clock);
		sr(`SNSR_OP_STATUS_LO, 8'h00);
		op(`SNSR_OP_WRITE_ENABLE);
		chk(8'(write_enable_latch), 8'h01);
		sr(`SNSR_OP_STATUS_LO, 8'h02);
		op(`SNSR_OP_WRITE_DISABLE);
		sr(`SNSR_OP_STATUS_LO, 8'h00);
		op(`SNSR_OP_WRITE_ENABLE);
		wsr({8'h7f, 8'hc2}, 16);
		chk(8'(write_in_progress_flag), 8'h01);
		sr(`SNSR_OP_STATUS_LO, 8'h03);
		repeat (TW + 20) @(negedge clock);
		chk({6'h00, write_enable_latch, write_in_progress_flag}, 8'h00);
		sr(`SNSR_OP_STATUS_LO, 8'h7c);
		sr(`SNSR_OP_STATUS_HI, 8'h42);
		chk(status_word[7:0], 8'h7c);
		chk(status_word[15:8], 8'h42);
		wsr({8'h00, 8'h00}, 16);
		repeat (TW + 20) @(negedge clock);
		sr(`SNSR_OP_STATUS_LO, 8'h7c);
		op(`SNSR_OP_WRITE_ENABLE);
		wsr(16'h001c, 8);
		repeat (TW + 20) @(negedge clock);
		sr(`SNSR_OP_STATUS_LO, 8'h1c);
		sr(`SNSR_OP_STATUS_HI, 8'h00);
		op(`SNSR_OP_WRITE_ENABLE);
		wsr(16'h0fff, 12);
		sr(`SNSR_OP_STATUS_LO, 8'h1e);
		op(`SNSR_OP_WRITE_DISABLE);
		op(`SNSR_OP_VOLATILE_ENABLE);
		wsr(16'h0080, 8);
		sr(`SNSR_OP_STATUS_LO, 8'h80);
		@(negedge clock);
		wp_n = 1'b0;
		op(`SNSR_OP_WRITE_ENABLE);
		wsr(16'h0000, 8);
		sr(`SNSR_OP_STATUS_LO, 8'h82);
		@(negedge clock);
		wp_n = 1'b1;
		op(`SNSR_OP_WRITE_DISABLE);
		op(`SNSR_OP_VOLATILE_ENABLE);
		wsr({8'h00, 8'h02}, 16);
		sr(`SNSR_OP_STATUS_LO, 8'h00);
		sr(`SNSR_OP_STATUS_HI, 8'h02);
		a = 24'($urandom % 1000);
		mr(`SNSR_OP_READ, a, 1, 0, 8'h00, 0, 1);
		mr(`SNSR_OP_FAST_READ, a + 24'h1, 1, 0, 8'h00, 8, 1);
		mr(`SNSR_OP_DUAL_OUT, a + 24'h2, 1, 0, 8'h00, 8, 2);
		mr(`SNSR_OP_QUAD_OUT, a + 24'h3, 1, 0, 8'h00, 8, 4);
		mr(`SNSR_OP_DUAL_IO, a + 24'h4, 2, 8, 8'h20, 0, 2);
		mr(8'h00, a + 24'h5, 2, 8, 8'h00, 0, 2);
		mr(`SNSR_OP_QUAD_IO, a + 24'h6, 4, 8, 8'h00, 4, 4);
		mr(`SNSR_OP_READ, 24'h0003fe, 1, 0, 8'h00, 0, 1);
		exp_q.push_back(sec_m[1]);
		exp_q.push_back(sec_m[2]);
		rd(`SNSR_OP_SEC_READ, 24'h000201, 24, 1, 0, 8'h00, 8, 1, 2);
		exp_q.push_back(8'hff);
		rd(`SNSR_OP_SEC_READ, 24'h000400, 24, 1, 0, 8'h00, 8, 1, 1);
		@(negedge clock);
		array_busy = 1'b1;
		sr(`SNSR_OP_STATUS_LO, 8'h01);
		i_host.start();
		i_host.put(32'(`SNSR_OP_READ), 8, 1);
		i_host.put(32'(a), 24, 1);
		#1;
		chk(8'(io_oe), 8'h00);
		i_host.put(32'h0, 8, 1);
		i_host.stop();
		@(negedge clock);
		array_busy = 1'b0;
		op(`SNSR_OP_WRITE_ENABLE);
		@(negedge clock);
		array_done = 1'b1;
		@(negedge clock);
		array_done = 1'b0;
		sr(`SNSR_OP_STATUS_LO, 8'h00);
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
